// ==== bench/radio_gain_control_config_test.sv ====
`include "rgc_defines.vh"
`default_nettype none
module radio_gain_control_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, reset_n = 0, awv = 0, wv = 0, arv = 0, sv = 0;
	logic [`RGC_AW-1:0] awa = 0, ara = 0;
	logic [7:0] wd = 0, ss = 0;
	logic [7:0] sp [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
	logic [7:0] rl [4] = '{8'h00, 8'h06, 8'h0A, 8'h0E};
	logic [3:0] ac [4] = '{4'h7, 4'h9, 4'hF, 4'h1};
	logic [7:0] th [4] = '{8'h28, 8'h1A, 8'h20, 8'h22};
	wire logic awr, wr, bv, arr, rv, cs;
	wire logic [1:0] br, rr, a1;
	wire logic [2:0] dg, a2;
	wire logic [31:0] rdat;
	int n_mismatch = 0, n_tests = 0;
	always #12.5 core_clk = ~core_clk;
	rgc_gain_ctrl u_rgc_gain_ctrl (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata({24'h000000, wd}), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
		.sig_strength(ss), .sig_strength_valid(sv), .digital_gain_r(dg), .amp1_att_r(a1), .amp2_att_r(a2),
		.carrier_sense_r(cs));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// responders are always ready, so the handshake edge is the first one with valid high
	task wreg(input logic [`RGC_AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
		int i;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
			if (awr) awv <= 0;
			if (wr) wv <= 0;
		end while (!bv && i < 50);
		check(br, er);
		if (i >= 50) begin
			n_mismatch++;
			end_of_test;
		end
	endtask
	task rreg(input logic [`RGC_AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
		int i;
		ara <= a;
		arv <= 1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
			if (arr) arv <= 0;
		end while (!rv && i < 50);
		check(rdat, {24'h000000, d});
		check(rr, er);
		if (i >= 50) begin
			n_mismatch++;
			end_of_test;
		end
	endtask
	task smp(input logic [7:0] s);
		ss <= s;
		sv <= 1;
		@(posedge core_clk);
		sv <= 0;
		@(posedge core_clk);
	endtask
	initial begin
		int k;
		repeat (4) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		check(cs, 0);
		rreg(`RGC_ADDR_LIMIT, `RGC_LIMIT_RST, `RGC_RESP_OKAY);
		rreg(`RGC_ADDR_ORDER, `RGC_ORDER_RST, `RGC_RESP_OKAY);
		rreg(20'h00010, 8'h00, `RGC_RESP_SLVERR);
		wreg(20'h00010, 8'h5A, `RGC_RESP_SLVERR);
		wreg(`RGC_ADDR_ORDER, 8'hFF, `RGC_RESP_OKAY);
		rreg(`RGC_ADDR_ORDER, 8'h7F, `RGC_RESP_OKAY);
		wreg(`RGC_ADDR_ORDER, 8'h40, `RGC_RESP_OKAY);
		for (k = 0; k < 8; k++) begin
			wreg(`RGC_ADDR_LIMIT, k[7:0], `RGC_RESP_OKAY);
			smp(sp[k] - 8'h01);
			check(cs, 0);
			smp(sp[k]);
			check(cs, 1);
		end
		// thresholds below are offsets from the 33 dB setpoint
		wreg(`RGC_ADDR_LIMIT, `RGC_LIMIT_RST, `RGC_RESP_OKAY);
		for (k = 0; k < 4; k++) begin
			wreg(`RGC_ADDR_ORDER, {4'h4, ac[k]}, `RGC_RESP_OKAY);
			smp(th[k] - 8'h01);
			check(cs, 0);
			smp(th[k]);
			check(cs, 1);
		end
		wreg(`RGC_ADDR_ORDER, 8'h48, `RGC_RESP_OKAY);
		smp(8'hFF);
		check(cs, 0);
		for (k = 1; k < 4; k++) begin
			wreg(`RGC_ADDR_ORDER, {2'b01, k[1:0], 4'h8}, `RGC_RESP_OKAY);
			smp(8'h64);
			smp(8'h63 + rl[k]);
			check(cs, 0);
			smp(8'h63 + rl[k] + rl[k]);
			check(cs, 1);
		end
		wreg(`RGC_ADDR_ORDER, 8'h48, `RGC_RESP_OKAY);
		// a weak input raises digital gain to its cap and strips front attenuation down to the floor
		for (k = 0; k < 4; k++) begin
			wreg(`RGC_ADDR_LIMIT, {k[1:0], 6'h03}, `RGC_RESP_OKAY);
			repeat (20) smp(8'h00);
			check(dg, 7 - k);
		end
		for (k = 0; k < 8; k++) begin
			wreg(`RGC_ADDR_LIMIT, {2'b00, k[2:0], 3'h3}, `RGC_RESP_OKAY);
			repeat (20) smp(8'h00);
			check(a1 + a2, k);
		end
		for (k = 0; k < 2; k++) begin
			wreg(`RGC_ADDR_LIMIT, 8'h03, `RGC_RESP_OKAY);
			repeat (20) smp(8'h00);
			wreg(`RGC_ADDR_ORDER, {1'b0, k[0], 6'h08}, `RGC_RESP_OKAY);
			smp(8'hC8);
			check(a1, k);
			check(a2, 1 - k);
		end
		rreg(`RGC_ADDR_STATUS, 8'h71, `RGC_RESP_OKAY);
		end_of_test;
	end
endmodule // radio_gain_control_config_test
`default_nettype wire

// ==== bench/rgc_checker.sv ====
`default_nettype none
module rgc_checker (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sig_strength_valid,
	input wire logic carrier_sense_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not refused");
	chk_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write not reopened");
	chk_sense_cause: assert property ($rose(carrier_sense_r) |-> $past(sig_strength_valid))
		else $error("sense rose without sample");
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_sense: cover property ($rose(carrier_sense_r));
endmodule // rgc_checker

bind rgc_gain_ctrl rgc_checker u_rgc_checker (.*);
`default_nettype wire

// ==== core/placeholder_none.v ====
`default_nettype none
`default_nettype wire

// ==== core/rgc_defines.vh ====
`ifndef RGC_DEFINES_VH
`define RGC_DEFINES_VH
// register indices as printed; the byte address is four times the index
`define RGC_IDX_LIMIT 16'hDF17
`define RGC_IDX_ORDER 16'hDF18
`define RGC_ADDR_LIMIT 20'h37C5C
`define RGC_ADDR_ORDER 20'h37C60
`define RGC_ADDR_STATUS 20'h37C80
`define RGC_AW 20
// gain_limit_and_setpoint fields
`define RGC_DCAP_HI 7
`define RGC_DCAP_LO 6
`define RGC_FCAP_HI 5
`define RGC_FCAP_LO 3
`define RGC_SETP_HI 2
`define RGC_SETP_LO 0
`define RGC_LIMIT_RST 8'h03
// gain_order_and_sense_thresholds fields
`define RGC_ORDER_BIT 6
`define RGC_REL_HI 5
`define RGC_REL_LO 4
`define RGC_ABS_HI 3
`define RGC_ABS_LO 0
`define RGC_ORDER_RST 8'h40
`define RGC_ORDER_MASK 8'h7F
`define RGC_ABS_OFF 4'h8
// gain stage ranges
`define RGC_DGAIN_MAX 3'h7
`define RGC_AMP1_ATT_MAX 2'h3
`define RGC_AMP2_ATT_MAX 3'h7
// relative rise thresholds in dB
`define RGC_REL1_DB 8'h06
`define RGC_REL2_DB 8'h0A
`define RGC_REL3_DB 8'h0E
// amplitude setpoints in dB
`define RGC_SP0_DB 8'h18
`define RGC_SP1_DB 8'h1B
`define RGC_SP2_DB 8'h1E
`define RGC_SP3_DB 8'h21
`define RGC_SP4_DB 8'h24
`define RGC_SP5_DB 8'h26
`define RGC_SP6_DB 8'h28
`define RGC_SP7_DB 8'h2A
`define RGC_RESP_OKAY 2'h0
`define RGC_RESP_SLVERR 2'h2
`endif

// ==== core/rgc_gain_ctrl.v ====
// Chosen here: the AXI4-Lite register port.
`include "rgc_defines.vh"
`default_nettype none

// Summary of operation
// - digital gain never exceeds top setting minus the two-bit cap code.
// - combined front-end attenuation never falls below the three-bit cap code.
// - loop steers measured amplitude toward setpoint 24,27,30,33,36,38,40,42 dB.
// - order bit 1 reduces stage one first; 0 floors stage two first.
// - relative test off at 00, else needs rise of 6, 10, 14 dB.
// - absolute threshold is signed 1 dB offset from setpoint, -7 to +7.
// - absolute code 1000 disables the absolute test entirely.
module rgc_gain_ctrl (
	input wire core_clk,
	input wire reset_n,
	input wire [`RGC_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`RGC_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] sig_strength,
	input wire sig_strength_valid,
	output reg [2:0] digital_gain_r,
	output reg [1:0] amp1_att_r,
	output reg [2:0] amp2_att_r,
	output reg carrier_sense_r
);

	// register map (byte addresses, one aligned word each):
	//   limit register: digital gain cap, front-end cap, amplitude setpoint
	//   order register: reduction order, relative and absolute sense thresholds
	//   status register: carrier sense and the present gain steps, read only
	// unused upper data bits read as 0 and are ignored on write
	// a write reaches the registers two edges after its later half is taken;
	// a read answers one edge after its address is taken
	// only byte lane 0 carries register data, so a write without strobe bit 0
	// is answered OKAY but changes nothing
	// an unmapped address answers SLVERR and reads as 0

	// configuration registers
	reg [7:0] limit_reg_r;
	reg [7:0] order_reg_r;
	// previous sample, reference for the relative test
	reg [7:0] ref_strength_r;
	// write halves held until both have arrived
	reg aw_held_r;
	reg w_held_r;
	reg [`RGC_AW-1:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	// combinational next values and lookups
	reg [7:0] setpoint_db;
	reg [7:0] rel_db;
	reg [31:0] rd_nxt;
	reg rd_ok;
	reg [2:0] digital_gain_nxt;
	reg [1:0] amp1_att_nxt;
	reg [2:0] amp2_att_nxt;
	reg carrier_sense_nxt;
	reg [7:0] ref_strength_nxt;
	// field views of the configuration registers
	wire [1:0] dcap = limit_reg_r[`RGC_DCAP_HI:`RGC_DCAP_LO];
	wire [2:0] fcap = limit_reg_r[`RGC_FCAP_HI:`RGC_FCAP_LO];
	wire [2:0] setp = limit_reg_r[`RGC_SETP_HI:`RGC_SETP_LO];
	wire order_first = order_reg_r[`RGC_ORDER_BIT];
	wire [1:0] rel_code = order_reg_r[`RGC_REL_HI:`RGC_REL_LO];
	wire [3:0] abs_code = order_reg_r[`RGC_ABS_HI:`RGC_ABS_LO];
	// highest digital step the cap still allows
	wire [2:0] dgain_top = `RGC_DGAIN_MAX - {1'b0, dcap};
	// total front-end attenuation in steps, wide enough for 3 + 7
	wire [3:0] front_att = {2'b00, amp1_att_r} + {1'b0, amp2_att_r};
	// absolute threshold: sign-extended code added to the setpoint; the setpoint
	// is at least 24 dB, so the sum never goes negative
	// relative threshold: measured against the previous sample, so the first
	// sample after reset is measured against zero
	wire abs_on = (abs_code != `RGC_ABS_OFF);
	wire rel_on = (rel_code != 2'b00);
	wire [9:0] abs_level = {2'b00, setpoint_db} + {{6{abs_code[3]}}, abs_code};
	wire abs_hit = abs_on && ({2'b00, sig_strength} >= abs_level);
	wire [8:0] rel_level = {1'b0, ref_strength_r} + {1'b0, rel_db};
	wire rel_hit = rel_on && ({1'b0, sig_strength} >= rel_level);
	// exact equality with the setpoint leaves the gains where they are
	wire too_strong = sig_strength > setpoint_db;
	wire too_weak = sig_strength < setpoint_db;
	// commit only when no response is waiting, so bresp is never overwritten
	wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	wire [31:0] status_word = {20'h00000, carrier_sense_r, amp2_att_r, 1'b0, digital_gain_r, 2'b00, amp1_att_r};
	// address decode on word boundaries; the two low address bits are ignored
	wire [`RGC_AW-1:0] aw_word = {aw_addr_r[`RGC_AW-1:2], 2'b00};
	wire [`RGC_AW-1:0] ar_word = {s_axi_araddr[`RGC_AW-1:2], 2'b00};
	wire wr_to_limit = (aw_word == `RGC_ADDR_LIMIT);
	wire wr_to_order = (aw_word == `RGC_ADDR_ORDER);
	wire wr_lane0 = w_strb_r[0];

	// setpoint lookup in dB
	always @* begin
		case (setp)
			3'h0: setpoint_db = `RGC_SP0_DB;
			3'h1: setpoint_db = `RGC_SP1_DB;
			3'h2: setpoint_db = `RGC_SP2_DB;
			3'h3: setpoint_db = `RGC_SP3_DB;
			3'h4: setpoint_db = `RGC_SP4_DB;
			3'h5: setpoint_db = `RGC_SP5_DB;
			3'h6: setpoint_db = `RGC_SP6_DB;
			default: setpoint_db = `RGC_SP7_DB;
		endcase
	end

	always @* begin
		case (rel_code)
			2'h1: rel_db = `RGC_REL1_DB;
			2'h2: rel_db = `RGC_REL2_DB;
			2'h3: rel_db = `RGC_REL3_DB;
			default: rel_db = 8'h00;
		endcase
	end

	// gain stepping: one step per sample; attenuation favours the front end so the
	// digital stage keeps headroom, recovery gives digital gain back first
	always @* begin
		digital_gain_nxt = digital_gain_r;
		amp1_att_nxt = amp1_att_r;
		amp2_att_nxt = amp2_att_r;
		// a lowered cap takes effect at once, without waiting for a sample
		if (digital_gain_r > dgain_top) begin
			digital_gain_nxt = dgain_top;
		// front-end floor: attenuate one step per edge until the cap is met
		end else if (front_att < {1'b0, fcap}) begin
			if (order_first && amp1_att_r != `RGC_AMP1_ATT_MAX) begin
				amp1_att_nxt = amp1_att_r + 2'h1;
			end else if (amp2_att_r != `RGC_AMP2_ATT_MAX) begin
				amp2_att_nxt = amp2_att_r + 3'h1;
			end else begin
				amp1_att_nxt = amp1_att_r + 2'h1;
			end
		// strong input: front end first, digital gain only once both stages are full
		end else if (sig_strength_valid && too_strong) begin
			if (order_first && amp1_att_r != `RGC_AMP1_ATT_MAX) begin
				amp1_att_nxt = amp1_att_r + 2'h1;
			end else if (amp2_att_r != `RGC_AMP2_ATT_MAX) begin
				amp2_att_nxt = amp2_att_r + 3'h1;
			end else if (amp1_att_r != `RGC_AMP1_ATT_MAX) begin
				amp1_att_nxt = amp1_att_r + 2'h1;
			end else if (digital_gain_r != 3'h0) begin
				digital_gain_nxt = digital_gain_r - 3'h1;
			end
		// weak input: digital gain first, then give back front-end attenuation
		end else if (sig_strength_valid && too_weak) begin
			if (digital_gain_r < dgain_top) begin
				digital_gain_nxt = digital_gain_r + 3'h1;
			end else if (front_att > {1'b0, fcap}) begin
				// restore in mirror order of reduction
				if (order_first) begin
					if (amp2_att_r != 3'h0) begin
						amp2_att_nxt = amp2_att_r - 3'h1;
					end else begin
						amp1_att_nxt = amp1_att_r - 2'h1;
					end
				end else begin
					if (amp1_att_r != 2'h0) begin
						amp1_att_nxt = amp1_att_r - 2'h1;
					end else begin
						amp2_att_nxt = amp2_att_r - 3'h1;
					end
				end
			end
		end
	end

	// carrier sense only moves on a sample; with both tests off it is forced low
	// at once, so a stale indication cannot outlive a change that turns both tests off
	always @* begin
		carrier_sense_nxt = carrier_sense_r;
		ref_strength_nxt = ref_strength_r;
		if (sig_strength_valid) begin
			carrier_sense_nxt = abs_hit || rel_hit;
			ref_strength_nxt = sig_strength;
		end else if (!abs_on && !rel_on) begin
			carrier_sense_nxt = 1'b0;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			// full front-end gain and lowest digital gain out of reset
			digital_gain_r <= 3'h0;
			amp1_att_r <= 2'h0;
			amp2_att_r <= 3'h0;
			carrier_sense_r <= 1'b0;
			ref_strength_r <= 8'h00;
		end else begin
			digital_gain_r <= digital_gain_nxt;
			amp1_att_r <= amp1_att_nxt;
			amp2_att_r <= amp2_att_nxt;
			carrier_sense_r <= carrier_sense_nxt;
			ref_strength_r <= ref_strength_nxt;
		end
	end

	// write path: address and data are latched independently, response after both
	// awready and wready drop when their half is taken and reopen only after the
	// response handshake, so at most one write is ever in flight
	// a single response slot: bvalid stands until bready, bresp with it
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			// both ready outputs idle high so either half can be taken first
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RGC_RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= {`RGC_AW{1'b0}};
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			limit_reg_r <= `RGC_LIMIT_RST;
			order_reg_r <= `RGC_ORDER_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RGC_RESP_OKAY;
				if (wr_to_limit) begin
					if (wr_lane0) begin
						limit_reg_r <= w_data_r[7:0];
					end
				end else if (wr_to_order) begin
					if (wr_lane0) begin
						order_reg_r <= w_data_r[7:0] & `RGC_ORDER_MASK;
					end
				end else begin
					s_axi_bresp <= `RGC_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @* begin
		rd_nxt = 32'h00000000;
		rd_ok = 1'b1;
		case (ar_word)
			`RGC_ADDR_LIMIT: rd_nxt = {24'h000000, limit_reg_r};
			`RGC_ADDR_ORDER: rd_nxt = {24'h000000, order_reg_r};
			`RGC_ADDR_STATUS: rd_nxt = status_word;
			default: rd_ok = 1'b0;
		endcase
	end

	// read data are captured with the address, so a register change while rvalid
	// stands does not disturb the word being returned
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			// one read in flight: arready stays low until the data are taken
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RGC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_nxt;
				s_axi_rresp <= rd_ok ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// limitations: the gain loop takes at most one step per edge, bar the digital cap clamp, and has no dead
	// zone or settling wait, so a noisy input can make it hunt by one step
	// the stage ranges (amp1 0..3, amp2 0..7, digital 0..7) are fixed here; a
	// front-end cap code is read as a minimum number of attenuation steps
	// the status word is a live view, captured when the read address is taken; gain
	// steps taken while rvalid stands do not change the word returned

endmodule // rgc_gain_ctrl

`default_nettype wire
